// ===== include/sdram_cmd_pkg.sv
package sdram_cmd_pkg;

  localparam logic [7:0]  CTRL_OFFSET     = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET   = 8'h04;
  localparam logic [7:0]  MODE_OFFSET     = 8'h08;
  localparam logic        CTRL_RESET      = 1'h1;
  localparam logic [11:0] MODE_RESET      = 12'h030;
  localparam int          BL_LSB          = 0;
  localparam int          BT_BIT          = 3;
  localparam int          CL_LSB          = 4;
  localparam int          WBL_BIT         = 9;
  localparam int          AP_BIT          = 10;
  localparam logic [2:0]  BL_FULL         = 3'h7;
  localparam logic [1:0]  MRS_CYCLES      = 2'h2;
  localparam int          ST_READ_BIT     = 4;
  localparam int          ST_WRITE_BIT    = 5;
  localparam int          ST_SUSPEND_BIT  = 6;
  localparam int          ST_PDOWN_BIT    = 7;
  localparam int          ST_SREF_BIT     = 8;
  localparam int          ST_MRS_BIT      = 9;

  typedef struct packed {
    logic        cke;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic [1:0]  ba;
    logic [11:0] addr;
    logic        high_byte_mask;
    logic        low_byte_mask;
  } pin_cmd_type;

  typedef enum logic [3:0] {
    op_deselect, op_nop, op_activate, op_precharge, op_read,
    op_write, op_mrs, op_refresh, op_stop
  } op_type;

  typedef enum logic [1:0] {
    ps_normal, ps_suspend, ps_powerdown, ps_selfrefresh
  } power_type;

endpackage : sdram_cmd_pkg

// ===== hdl/sdram_command_read_path.sv
`timescale 1ns/10ps
module sdram_command_read_path (
  input  wire logic                       hclk,      // Bus and device clock, 250 MHz
  input  wire logic                       hresetn,   // Asynchronous reset, active low
  input  wire logic                       en,        // Freezes the device state while low
  input  wire sdram_cmd_pkg::pin_cmd_type cmd,       // Command, bank, address and mask pins
  input  wire logic [15:0]                dq_in,     // Data pins as seen from outside
  output logic      [15:0]                dq_out,    // Data driven onto the pins
  output logic      [1:0]                 dq_oe_n,   // Per-byte drive enable, low drives
  input  wire logic                       hsel,      // AHB-Lite slave select
  input  wire logic [31:0]                haddr,     // AHB-Lite address
  input  wire logic [1:0]                 htrans,    // AHB-Lite transfer type
  input  wire logic                       hwrite,    // AHB-Lite write
  input  wire logic [2:0]                 hsize,     // AHB-Lite size, words only
  input  wire logic [31:0]                hwdata,    // AHB-Lite write data
  input  wire logic                       hready,    // AHB-Lite bus ready
  output logic      [31:0]                hrdata,    // AHB-Lite read data
  output logic                            hreadyout, // AHB-Lite slave ready
  output logic                            hresp      // AHB-Lite response, always OKAY
);

  function automatic logic [8:0] len_mask(input logic [2:0] code);
    unique case (code)
      3'h1:    len_mask = 9'h001;
      3'h2:    len_mask = 9'h003;
      3'h3:    len_mask = 9'h007;
      3'h7:    len_mask = 9'h1FF;
      default: len_mask = 9'h000;
    endcase
  endfunction : len_mask

  // Reserved length codes behave as a single-word burst.
  function automatic logic [8:0] col_at(input logic [8:0] start, input logic [8:0] idx,
                                        input logic [2:0] code, input logic inter);
    logic [8:0] m;
    m = len_mask(code);
    if (inter && code != sdram_cmd_pkg::BL_FULL) col_at = (start & ~m) | ((start ^ idx) & m);
    else col_at = (start & ~m) | ((start + idx) & m);
  endfunction : col_at

  function automatic sdram_cmd_pkg::op_type decode(input sdram_cmd_pkg::pin_cmd_type c);
    if (c.cs_n) decode = sdram_cmd_pkg::op_deselect;
    else begin
      unique case ({c.ras_n, c.cas_n, c.we_n})
        3'h7: decode = sdram_cmd_pkg::op_nop;
        3'h3: decode = sdram_cmd_pkg::op_activate;
        3'h2: decode = sdram_cmd_pkg::op_precharge;
        3'h5: decode = sdram_cmd_pkg::op_read;
        3'h4: decode = sdram_cmd_pkg::op_write;
        3'h0: decode = sdram_cmd_pkg::op_mrs;
        3'h1: decode = sdram_cmd_pkg::op_refresh;
        3'h6: decode = sdram_cmd_pkg::op_stop;
      endcase
    end
  endfunction : decode

  logic [15:0]              mem [256];
  logic [3:0]               bank_open,  next_bank_open;
  logic [11:0]              open_row [4];
  logic [11:0]              next_open_row [4];
  logic [11:0]              mode,       next_mode;
  logic [1:0]               mrs_left,   next_mrs_left;
  logic                     cke_prev,   next_cke_prev;
  sdram_cmd_pkg::power_type pstate,     next_pstate;
  logic                     rd_active,  next_rd_active;
  logic                     rd_ap,      next_rd_ap;
  logic [1:0]               rd_bank,    next_rd_bank;
  logic [8:0]               rd_start,   next_rd_start;
  logic [8:0]               rd_idx,     next_rd_idx;
  logic [9:0]               rd_left,    next_rd_left;
  logic                     wr_active,  next_wr_active;
  logic                     wr_ap,      next_wr_ap;
  logic [1:0]               wr_bank,    next_wr_bank;
  logic [8:0]               wr_start,   next_wr_start;
  logic [8:0]               wr_idx,     next_wr_idx;
  logic [9:0]               wr_left,    next_wr_left;
  logic                     pipe_valid, next_pipe_valid;
  logic [15:0]              pipe_data,  next_pipe_data;
  logic                     out_valid,  next_out_valid;
  logic [1:0]               dqm_d,      next_dqm_d;
  logic [15:0]              next_dq_out;
  logic [1:0]               next_dq_oe_n;
  logic                     ctrl_en,    next_ctrl_en;
  logic                     ahb_wr,     next_ahb_wr;
  logic [7:0]               ahb_addr,   next_ahb_addr;
  logic [31:0]              next_hrdata;

  sdram_cmd_pkg::op_type op;
  logic                  run;
  logic                  go;
  logic                  rd_go;
  logic                  rd_full;
  logic                  cl3;
  logic [2:0]            wcode;
  logic [8:0]            rd_col;
  logic [8:0]            wr_col;
  logic [15:0]           gen_data;
  logic                  mem_we;
  logic [7:0]            mem_waddr;
  logic [15:0]           mem_wdata;

  always_comb begin
    op       = decode(cmd);
    run      = en && cke_prev;
    go       = run && ctrl_en && (mrs_left == 2'h0);
    rd_go    = go && op == sdram_cmd_pkg::op_read && bank_open[cmd.ba];
    cl3      = mode[sdram_cmd_pkg::CL_LSB];
    rd_full  = mode[2:0] == sdram_cmd_pkg::BL_FULL;
    wcode    = mode[sdram_cmd_pkg::WBL_BIT] ? 3'h0 : mode[2:0];
    rd_col   = col_at(rd_start, rd_idx, mode[2:0], mode[sdram_cmd_pkg::BT_BIT]);
    wr_col   = col_at(wr_start, wr_idx, wcode, mode[sdram_cmd_pkg::BT_BIT]);
    gen_data = mem[{rd_bank, rd_col[5:0]}];
    mem_we    = 1'b0;
    mem_waddr = {wr_bank, wr_col[5:0]};
    mem_wdata = dq_in;
    next_bank_open = bank_open;
    next_open_row  = open_row;
    next_mode      = mode;
    next_mrs_left  = mrs_left;
    next_cke_prev  = cke_prev;
    next_pstate    = pstate;
    next_rd_active = rd_active;
    next_rd_ap     = rd_ap;
    next_rd_bank   = rd_bank;
    next_rd_start  = rd_start;
    next_rd_idx    = rd_idx;
    next_rd_left   = rd_left;
    next_wr_active = wr_active;
    next_wr_ap     = wr_ap;
    next_wr_bank   = wr_bank;
    next_wr_start  = wr_start;
    next_wr_idx    = wr_idx;
    next_wr_left   = wr_left;
    next_pipe_valid = pipe_valid;
    next_pipe_data  = pipe_data;
    next_out_valid  = out_valid;
    next_dqm_d      = dqm_d;
    next_dq_out     = dq_out;
    next_dq_oe_n    = dq_oe_n;
    if (en) begin
      next_cke_prev = cmd.cke;
      if (run && !cmd.cke) begin
        if (go && op == sdram_cmd_pkg::op_refresh) next_pstate = sdram_cmd_pkg::ps_selfrefresh;
        else if (rd_active || wr_active) next_pstate = sdram_cmd_pkg::ps_suspend;
        else next_pstate = sdram_cmd_pkg::ps_powerdown;
      end else if (!cke_prev && cmd.cke) begin
        next_pstate = sdram_cmd_pkg::ps_normal;
      end
    end
    if (run) begin
      if (mrs_left != 2'h0) next_mrs_left = mrs_left - 2'h1;
      next_dqm_d      = {cmd.high_byte_mask, cmd.low_byte_mask};
      next_pipe_valid = rd_active;
      next_pipe_data  = gen_data;
      next_out_valid  = cl3 ? pipe_valid : rd_active;
      next_dq_out     = cl3 ? pipe_data : gen_data;
      if (rd_active) begin
        next_rd_idx = rd_idx + 9'h001;
        if (!rd_full) begin
          next_rd_left = rd_left - 10'h001;
          if (rd_left == 10'h001) begin
            next_rd_active = 1'b0;
            if (rd_ap) next_bank_open[rd_bank] = 1'b0;
          end
        end
      end
      if (wr_active) begin
        mem_we      = 1'b1;
        next_wr_idx = wr_idx + 9'h001;
        if (wcode != sdram_cmd_pkg::BL_FULL) begin
          next_wr_left = wr_left - 10'h001;
          if (wr_left == 10'h001) begin
            next_wr_active = 1'b0;
            if (wr_ap) next_bank_open[wr_bank] = 1'b0;
          end
        end
      end
      if (go) begin
        unique case (op)
          sdram_cmd_pkg::op_activate: begin
            if (!bank_open[cmd.ba]) begin
              next_bank_open[cmd.ba] = 1'b1;
              next_open_row[cmd.ba]  = cmd.addr;
            end
          end
          sdram_cmd_pkg::op_precharge: begin
            if (cmd.addr[sdram_cmd_pkg::AP_BIT]) begin
              next_bank_open = 4'h0;
              next_rd_active = 1'b0;
              next_wr_active = 1'b0;
            end else begin
              next_bank_open[cmd.ba] = 1'b0;
              if (rd_bank == cmd.ba) next_rd_active = 1'b0;
              if (wr_bank == cmd.ba) next_wr_active = 1'b0;
            end
          end
          sdram_cmd_pkg::op_read: begin
            if (rd_go) begin
              next_rd_active = 1'b1;
              next_rd_bank   = cmd.ba;
              next_rd_start  = cmd.addr[8:0];
              next_rd_ap     = cmd.addr[sdram_cmd_pkg::AP_BIT] && !rd_full;
              next_rd_idx    = 9'h000;
              next_rd_left   = 10'(len_mask(mode[2:0])) + 10'h001;
              next_wr_active = 1'b0;
            end
          end
          sdram_cmd_pkg::op_write: begin
            if (bank_open[cmd.ba]) begin
              // A write takes the pins at once; in-flight read words are dropped.
              mem_we          = 1'b1;
              mem_waddr       = {cmd.ba, cmd.addr[5:0]};
              next_wr_bank    = cmd.ba;
              next_wr_start   = cmd.addr[8:0];
              next_wr_ap      = cmd.addr[sdram_cmd_pkg::AP_BIT] && wcode != sdram_cmd_pkg::BL_FULL;
              next_wr_idx     = 9'h001;
              next_wr_left    = 10'(len_mask(wcode));
              next_wr_active  = len_mask(wcode) != 9'h000;
              next_rd_active  = 1'b0;
              next_pipe_valid = 1'b0;
              next_out_valid  = 1'b0;
            end
          end
          sdram_cmd_pkg::op_mrs: begin
            if (bank_open == 4'h0) begin
              next_mode     = cmd.addr;
              next_mrs_left = sdram_cmd_pkg::MRS_CYCLES - 2'h1;
            end
          end
          sdram_cmd_pkg::op_stop: begin
            next_rd_active = 1'b0;
            next_wr_active = 1'b0;
          end
          default: begin
          end
        endcase
      end
      next_dq_oe_n = ~({2{next_out_valid}} & ~dqm_d);
    end
    if (mem_we) begin
      if (cmd.high_byte_mask) mem_wdata[15:8] = mem[mem_waddr][15:8];
      if (cmd.low_byte_mask) mem_wdata[7:0] = mem[mem_waddr][7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bank_open  <= 4'h0;
      open_row   <= '{default: 12'h000};
      mode       <= sdram_cmd_pkg::MODE_RESET;
      mrs_left   <= 2'h0;
      cke_prev   <= 1'b0;
      pstate     <= sdram_cmd_pkg::ps_normal;
      rd_active  <= 1'b0;
      rd_ap      <= 1'b0;
      rd_bank    <= 2'h0;
      rd_start   <= 9'h000;
      rd_idx     <= 9'h000;
      rd_left    <= 10'h000;
      wr_active  <= 1'b0;
      wr_ap      <= 1'b0;
      wr_bank    <= 2'h0;
      wr_start   <= 9'h000;
      wr_idx     <= 9'h000;
      wr_left    <= 10'h000;
      pipe_valid <= 1'b0;
      pipe_data  <= 16'h0000;
      out_valid  <= 1'b0;
      dqm_d      <= 2'h3;
      dq_out     <= 16'h0000;
      dq_oe_n    <= 2'h3;
    end else begin
      bank_open  <= next_bank_open;
      open_row   <= next_open_row;
      mode       <= next_mode;
      mrs_left   <= next_mrs_left;
      cke_prev   <= next_cke_prev;
      pstate     <= next_pstate;
      rd_active  <= next_rd_active;
      rd_ap      <= next_rd_ap;
      rd_bank    <= next_rd_bank;
      rd_start   <= next_rd_start;
      rd_idx     <= next_rd_idx;
      rd_left    <= next_rd_left;
      wr_active  <= next_wr_active;
      wr_ap      <= next_wr_ap;
      wr_bank    <= next_wr_bank;
      wr_start   <= next_wr_start;
      wr_idx     <= next_wr_idx;
      wr_left    <= next_wr_left;
      pipe_valid <= next_pipe_valid;
      pipe_data  <= next_pipe_data;
      out_valid  <= next_out_valid;
      dqm_d      <= next_dqm_d;
      dq_out     <= next_dq_out;
      dq_oe_n    <= next_dq_oe_n;
    end
  end

  // Storage covers six column bits per bank, so rows and high columns alias.
  always_ff @(posedge hclk) begin
    if (mem_we) mem[mem_waddr] <= mem_wdata;
  end

  // Zero-wait AHB-Lite slave; it keeps running while the device is frozen.
  always_comb begin
    next_ctrl_en  = ctrl_en;
    next_ahb_wr   = ahb_wr;
    next_ahb_addr = ahb_addr;
    next_hrdata   = hrdata;
    if (ahb_wr && ahb_addr == sdram_cmd_pkg::CTRL_OFFSET) next_ctrl_en = hwdata[0];
    if (hready) begin
      next_ahb_wr   = hsel && htrans[1] && hwrite;
      next_ahb_addr = {haddr[7:2], 2'h0};
      if (hsel && htrans[1] && !hwrite) begin
        unique case ({haddr[7:2], 2'h0})
          sdram_cmd_pkg::CTRL_OFFSET:   next_hrdata = {31'h0, ctrl_en};
          sdram_cmd_pkg::STATUS_OFFSET: begin
            next_hrdata = {28'h0, bank_open};
            next_hrdata[sdram_cmd_pkg::ST_READ_BIT]    = rd_active;
            next_hrdata[sdram_cmd_pkg::ST_WRITE_BIT]   = wr_active;
            next_hrdata[sdram_cmd_pkg::ST_SUSPEND_BIT] = pstate == sdram_cmd_pkg::ps_suspend;
            next_hrdata[sdram_cmd_pkg::ST_PDOWN_BIT]   = pstate == sdram_cmd_pkg::ps_powerdown;
            next_hrdata[sdram_cmd_pkg::ST_SREF_BIT]    = pstate == sdram_cmd_pkg::ps_selfrefresh;
            next_hrdata[sdram_cmd_pkg::ST_MRS_BIT]     = mrs_left != 2'h0;
          end
          sdram_cmd_pkg::MODE_OFFSET:   next_hrdata = {20'h0, mode};
          default:                      next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en   <= sdram_cmd_pkg::CTRL_RESET;
      ahb_wr    <= 1'b0;
      ahb_addr  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ctrl_en   <= next_ctrl_en;
      ahb_wr    <= next_ahb_wr;
      ahb_addr  <= next_ahb_addr;
      hrdata    <= next_hrdata;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence quiet_s;
    run && !(go && op == sdram_cmd_pkg::op_write);
  endsequence
  sequence rd_cl2_s;
    rd_go && !cl3 ##1 quiet_s;
  endsequence
  sequence rd_cl3_s;
    rd_go && cl3 ##1 quiet_s ##1 quiet_s;
  endsequence

  read_cl2_a: assert property (rd_cl2_s |=> out_valid)
    else $error("read word missing two clocks after the read");
  read_cl3_a: assert property (rd_cl3_s |=> out_valid)
    else $error("read word missing three clocks after the read");
  mask_latency_a: assert property (run ##1 run |=>
      dq_oe_n[0] == !(out_valid && !$past(cmd.low_byte_mask, 2)))
    else $error("low byte drive does not follow the mask of two clocks earlier");
  precharge_all_a: assert property (go && op == sdram_cmd_pkg::op_precharge
      && cmd.addr[sdram_cmd_pkg::AP_BIT] |=> bank_open == 4'h0)
    else $error("banks left open after precharge of every bank");
  precharge_one_a: assert property (go && op == sdram_cmd_pkg::op_precharge
      && !cmd.addr[sdram_cmd_pkg::AP_BIT] |=> !bank_open[$past(cmd.ba)])
    else $error("bank still open after its precharge");
  activate_row_a: assert property (go && op == sdram_cmd_pkg::op_activate
      && !bank_open[cmd.ba] |=> bank_open[$past(cmd.ba)]
      && open_row[$past(cmd.ba)] == $past(cmd.addr))
    else $error("activate did not open the bank with its row");
  suspend_entry_a: assert property (run && !cmd.cke && (rd_active || wr_active)
      |=> pstate == sdram_cmd_pkg::ps_suspend)
    else $error("clock enable drop in a burst did not suspend");
  page_wrap_a: assert property (run && rd_active && rd_full && rd_col == 9'h1FF
      && (op == sdram_cmd_pkg::op_nop || op == sdram_cmd_pkg::op_deselect)
      |=> rd_active && rd_col == 9'h000)
    else $error("full page burst did not wrap to column zero");
  mode_set_a: assert property (go && op == sdram_cmd_pkg::op_mrs && bank_open == 4'h0
      ##1 run |-> mrs_left != 2'h0 ##1 mrs_left == 2'h0)
    else $error("mode register set did not take two clocks");

endmodule : sdram_command_read_path

// ===== dv/sdram_ctrl_model.sv
`timescale 1ns/10ps
module sdram_ctrl_model #(
  parameter int GAP = 3 // Idle cycles after an activate, a plain default
) (
  input  wire logic                  hclk,   // Shared clock
  output sdram_cmd_pkg::pin_cmd_type cmd,    // Command pins toward the device
  output logic [15:0]                ctl_dq  // Controller drive, or noise when released
);
  logic        drive;
  logic [15:0] wdat;
  logic [15:0] spin;
  initial begin
    cmd = '0;
    cmd.cke = 1'b1;
    cmd.cs_n = 1'b1;
    drive = 1'b0;
    wdat = 16'h0000;
    spin = 16'h0000;
  end
  // A released wire has no keeper, so it shows a value that moves every cycle.
  always @(posedge hclk) spin <= spin + 16'h3C5B;
  assign ctl_dq = drive ? wdat : spin;
  // Pins change just after an edge and hold through the next one.
  task automatic issue(input logic [3:0] op, input logic [1:0] b, input logic [11:0] a,
                       input logic [1:0] m, input logic de, input logic [15:0] d);
    {cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} <= op;
    cmd.ba <= b;
    cmd.addr <= a;
    {cmd.high_byte_mask, cmd.low_byte_mask} <= m;
    drive <= de;
    wdat <= d;
    @(posedge hclk);
  endtask : issue
  // Sets the clock-enable pin for the next edge and sends a no-operation with it.
  task automatic hold(input logic k);
    cmd.cke <= k;
    issue(4'h7, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
  endtask : hold
  // The idle gap covers row-to-column and bank-to-bank spacing.
  task automatic activate(input logic [1:0] b, input logic [11:0] row);
    issue(4'h3, b, row, 2'h0, 1'b0, 16'h0000);
    repeat (GAP) issue(4'h7, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
  endtask : activate
endmodule : sdram_ctrl_model

// ===== dv/tb.sv
`timescale 1ns/10ps
module tb;
  logic hclk, hresetn, en, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]  htrans, dq_oe_n;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] dq_in, dq_out, ctl_dq;
  sdram_cmd_pkg::pin_cmd_type cmd;
  int error_cnt = 0;
  int num_checks = 0;
  assign hready = hreadyout;
  assign dq_in[15:8] = dq_oe_n[1] ? ctl_dq[15:8] : dq_out[15:8];
  assign dq_in[7:0] = dq_oe_n[0] ? ctl_dq[7:0] : dq_out[7:0];
  sdram_ctrl_model ctl (.hclk(hclk), .cmd(cmd), .ctl_dq(ctl_dq));
  sdram_command_read_path dut (.hclk(hclk), .hresetn(hresetn), .en(en), .cmd(cmd),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsel <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic nop(input logic [1:0] m);
    ctl.issue(4'h7, 2'h0, 12'h000, m, 1'b0, 16'h0000);
  endtask : nop
  task automatic test_regs;
    ahb(1'b0, 32'h0, 32'h0); chk("ctrl", rd, 32'h1);
    chk("hresp", hresp, 32'h0);
    chk("hreadyout", hreadyout, 32'h1);
    ahb(1'b0, 32'h4, 32'h0); chk("status", rd, 32'h0);
    ahb(1'b1, 32'h8, 32'h0);
    ahb(1'b0, 32'h8, 32'h0); chk("mode", rd, 32'h030);
    ahb(1'b0, 32'hC, 32'h0); chk("unmapped", rd, 32'h0);
    ctl.issue(4'h0, 2'h0, 12'h022, 2'h0, 1'b0, 16'h0000);
    nop(2'h0);
    ahb(1'b0, 32'h8, 32'h0); chk("mode_set", rd, 32'h022);
  endtask : test_regs
  task automatic test_banks;
    ctl.activate(2'h0, 12'h005);
    ctl.activate(2'h1, 12'h009);
    ctl.issue(4'hB, 2'h2, 12'h001, 2'h0, 1'b0, 16'h0000);
    ahb(1'b0, 32'h4, 32'h0); chk("open", rd[3:0], 4'h3);
    ctl.issue(4'h0, 2'h0, 12'h023, 2'h0, 1'b0, 16'h0000);
    nop(2'h0);
    ahb(1'b0, 32'h8, 32'h0); chk("mode_busy", rd, 32'h022);
    ctl.issue(4'h2, 2'h0, 12'h000, 2'h0, 1'b0, 16'h0000);
    ahb(1'b0, 32'h4, 32'h0); chk("one_closed", rd[3:0], 4'h2);
    ctl.issue(4'h2, 2'h1, 12'h400, 2'h0, 1'b0, 16'h0000);
    ahb(1'b0, 32'h4, 32'h0); chk("all_closed", rd[3:0], 4'h0);
  endtask : test_banks
  task automatic test_burst;
    logic [15:0] w;
    ctl.activate(2'h1, 12'h007);
    for (int i = 0; i < 4; i++) begin
      ctl.issue(i == 0 ? 4'h4 : 4'h7, 2'h1, 12'h004, 2'h0, 1'b1, 16'h1000 + 16'(i) * 16'h0111);
    end
    nop(2'h0);
    ctl.issue(4'h5, 2'h1, 12'h004, 2'h0, 1'b0, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      nop(i == 1 ? 2'h2 : 2'h0);
      #1;
      w = 16'h1000 + 16'(i) * 16'h0111;
      chk("oe", dq_oe_n, i > 3 ? 2'h3 : (i == 2 ? 2'h2 : 2'h0));
      if (i < 4) chk("lo", dq_out[7:0], w[7:0]);
      if (i < 4 && i != 2) chk("hi", dq_out[15:8], w[15:8]);
    end
    ctl.issue(4'h5, 2'h1, 12'h004, 2'h0, 1'b0, 16'h0000);
    ctl.issue(4'h5, 2'h1, 12'h006, 2'h0, 1'b0, 16'h0000);
    nop(2'h0);
    #1;
    chk("new0", dq_out, 16'h1222);
    nop(2'h0);
    #1;
    chk("new1", dq_out, 16'h1333);
    ctl.issue(4'h2, 2'h1, 12'h400, 2'h0, 1'b0, 16'h0000);
    repeat (4) nop(2'h0);
    #1;
    chk("released", dq_oe_n, 2'h3);
  endtask : test_burst
  task automatic test_suspend;
    ctl.activate(2'h2, 12'h003);
    ctl.issue(4'h5, 2'h2, 12'h000, 2'h0, 1'b0, 16'h0000);
    ctl.hold(1'b0);
    ahb(1'b0, 32'h4, 32'h0); chk("suspend", rd, 32'h54);
    ctl.hold(1'b1);
    ctl.issue(4'h2, 2'h0, 12'h400, 2'h0, 1'b0, 16'h0000);
    ahb(1'b0, 32'h4, 32'h0); chk("resumed", rd, 32'h0);
  endtask : test_suspend
  initial begin
    hresetn = 1'b0;
    en = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    test_regs();
    test_banks();
    test_burst();
    test_suspend();
    end_sim();
  end
  // The whole run needs under a hundred cycles, so this only catches a hang.
  initial begin
    repeat (3000) @(posedge hclk);
    error_cnt++;
    end_sim();
  end
endmodule : tb
